/* File: core/ivp_defines.svh */
// register offsets, reset values, field positions and vector slots
// assumes: included by bare name from the top module
`ifndef IVP_DEFINES_SVH
`define IVP_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IVP_OFS_PRIO 8'h00
`define IVP_OFS_CHEN 8'h01
`define IVP_OFS_CTRL 8'h02
`define IVP_OFS_STAT 8'h03
`define IVP_OFS_VLOW 8'h04

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IVP_RST_PRIO 8'hF2
`define IVP_RST_CHEN 8'h00
`define IVP_RST_CTRL 8'h00

// ----------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------
`define IVP_CTRL_TOF 0
`define IVP_CTRL_PAA 1
`define IVP_CTRL_PAE 2
`define IVP_CTRL_MDC 3
`define IVP_CTRL_PAB 4
`define IVP_CTRL_CLKMON 5
`define IVP_CTRL_SELFCLK 6
`define IVP_CTRL_MASK 8'h7F

// ----------------------------------------------------------------
// vector slots: vector = FF80 + 2 * slot
// ----------------------------------------------------------------
`define IVP_VEC_PAGE 8'hFF
`define IVP_SLOT_RESET 6'h3F
`define IVP_SLOT_CMF 6'h3E
`define IVP_SLOT_WDOG 6'h3D
`define IVP_SLOT_TRAP 6'h3C
`define IVP_SLOT_SWT 6'h3B
`define IVP_SLOT_XREQ 6'h3A
`define IVP_SLOT_MTOP 6'h39
`define IVP_SLOT_MBOT 6'h06
`define IVP_SLOT_CH0 6'h37
`define IVP_SLOT_CH7 6'h30
`define IVP_SLOT_TOF 6'h2F
`define IVP_SLOT_PAA 6'h2E
`define IVP_SLOT_PAE 6'h2D
`define IVP_SLOT_MDC 6'h25
`define IVP_SLOT_PAB 6'h24

`endif

/* File: core/ivp_pkg.sv */
// types shared by the vector and priority logic
// assumes: nothing beyond the defines header
package ivp_pkg;
  // index of a two-byte vector slot above FF80
  typedef logic [5:0] ivp_slot_t;
  // result of a priority search
  typedef struct packed {
    logic      found;
    ivp_slot_t slot;
  } ivp_pick_t;
endpackage

/* File: core/ivp_top.sv */
// interrupt vector and priority resolver with its control registers
// assumes: one 40 MHz clock, synchronous inputs, cpu supplies mask flags
//
// What this block does
// - higher vector address wins among pending sources, except an elevated maskable source beats other maskable ones
// - clock failure resets via FFFC when the monitor is enabled and self clock mode is off
// - capture channels FFEE..FFE0, maskable, enabled, elevatable
// - timer overflow FFDE, maskable, enabled, elevatable
// - accumulator A overflow FFDC, maskable, enabled
// - accumulator edge FFDA, maskable, enabled, elevatable
// - down counter underflow FFCA, maskable, enabled
// - accumulator B overflow FFC8, maskable, enabled
// - reset returns all registers to start values
`timescale 1ns/1ps
`default_nettype none
`include "ivp_defines.svh"

module ivp_top #(
  parameter int NUM_SLOTS = 64      // two-byte slots FF80..FFFE
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 srst_in,
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output var  logic [7:0]           reg_rdata_out,
  input  wire logic [NUM_SLOTS-1:0] src_req_in,
  input  wire logic                 clk_fail_in,
  input  wire logic                 cc_i_mask_in,
  input  wire logic                 cc_x_mask_in,
  output var  logic                 irq_valid_out,
  output var  logic [15:0]          vector_addr_out
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // highest set slot in a request vector
  // a plain scan; it maps onto a priority encoder
  function automatic ivp_pkg::ivp_pick_t top_slot(
    input logic [NUM_SLOTS-1:0] vec
  );
    ivp_pkg::ivp_pick_t pick;
    pick = '0;
    // later hits overwrite earlier ones, so the highest slot wins
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (vec[i]) begin
        pick.found = 1'b1;
        pick.slot  = ivp_pkg::ivp_slot_t'(i);
      end
    end
    return pick;
  endfunction

  // slot named by an elevation value, found only for maskable slots
  function automatic ivp_pkg::ivp_pick_t slot_of_value(
    input logic [7:0] value
  );
    ivp_pkg::ivp_pick_t pick;
    // bit 7 set, bit 0 clear: only even low bytes inside the page count
    pick.slot  = value[6:1];
    pick.found = value[7] && !value[0]
              && (value[6:1] <= `IVP_SLOT_MTOP)
              && (value[6:1] >= `IVP_SLOT_MBOT);
    return pick;
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] priority_elevation_value_ff;  // elevated source low byte
  logic [7:0] nxt_priority_elevation_value;
  logic [7:0] chan_irq_enable_ff;           // capture channel enables
  logic [7:0] nxt_chan_irq_enable;
  logic [7:0] ctrl_ff;                      // other local enables
  logic [7:0] nxt_ctrl;
  logic [7:0] rdata_ff;                     // read data, one cycle late
  logic [7:0] nxt_rdata;

  // ----------------------------------------------------------------
  // resolver state
  // ----------------------------------------------------------------
  // registering the winner keeps the long search off the cpu fetch path
  logic        irq_valid_ff;                // a source is winning
  logic        nxt_irq_valid;
  logic [15:0] vector_ff;                   // winning vector address
  logic [15:0] nxt_vector;

  // ----------------------------------------------------------------
  // named enable bits
  // ----------------------------------------------------------------
  logic timer_overflow_irq_enable;
  logic accum_a_overflow_irq_enable;
  logic accum_edge_irq_enable;
  logic down_counter_zero_irq_enable;
  logic accum_b_overflow_irq_enable;
  logic clock_monitor_enable;
  logic self_clock_mode_enable;

  // named views of the control bits keep the gating below readable
  assign timer_overflow_irq_enable    = ctrl_ff[`IVP_CTRL_TOF];
  assign accum_a_overflow_irq_enable  = ctrl_ff[`IVP_CTRL_PAA];
  assign accum_edge_irq_enable        = ctrl_ff[`IVP_CTRL_PAE];
  assign down_counter_zero_irq_enable = ctrl_ff[`IVP_CTRL_MDC];
  assign accum_b_overflow_irq_enable  = ctrl_ff[`IVP_CTRL_PAB];
  assign clock_monitor_enable         = ctrl_ff[`IVP_CTRL_CLKMON];
  assign self_clock_mode_enable       = ctrl_ff[`IVP_CTRL_SELFCLK];

  // ----------------------------------------------------------------
  // local enable gating
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] gated_req;          // after local enables

  // apply the enables this block owns; others arrive pre-gated
  always_comb begin
    gated_req = src_req_in;
    // slot 62 never follows the request bus, only the monitor input
    // clock failure raises a reset only with monitor on, self clock off
    gated_req[`IVP_SLOT_CMF] = clk_fail_in && clock_monitor_enable
                            && !self_clock_mode_enable;
    // channel 0 at FFEE down to channel 7 at FFE0
    for (int c = 0; c < 8; c++) begin
      gated_req[int'(`IVP_SLOT_CH0) - c] =
        src_req_in[int'(`IVP_SLOT_CH0) - c]
        && chan_irq_enable_ff[c];
    end
    gated_req[`IVP_SLOT_TOF] = src_req_in[`IVP_SLOT_TOF]
                            && timer_overflow_irq_enable;
    gated_req[`IVP_SLOT_PAA] = src_req_in[`IVP_SLOT_PAA]
                            && accum_a_overflow_irq_enable;
    gated_req[`IVP_SLOT_PAE] = src_req_in[`IVP_SLOT_PAE]
                            && accum_edge_irq_enable;
    gated_req[`IVP_SLOT_MDC] = src_req_in[`IVP_SLOT_MDC]
                            && down_counter_zero_irq_enable;
    gated_req[`IVP_SLOT_PAB] = src_req_in[`IVP_SLOT_PAB]
                            && accum_b_overflow_irq_enable;
    // slots below the lowest maskable vector are reserved
    for (int r = 0; r < int'(`IVP_SLOT_MBOT); r++) begin
      gated_req[r] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mask flags
  // ----------------------------------------------------------------
  // three views of the requests after the condition flags
  logic [NUM_SLOTS-1:0] unmasked_req;       // after condition flags
  logic [NUM_SLOTS-1:0] maskable_req;       // unmasked i-flag sources
  logic [NUM_SLOTS-1:0] fixed_req;          // non i-flag sources

  // i flag blocks maskable slots, x flag only the external request
  always_comb begin
    // slot index alone decides the masking class of a source
    unmasked_req = gated_req;
    maskable_req = '0;
    fixed_req    = '0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (s <= int'(`IVP_SLOT_MTOP)) begin
        // maskable class, includes all capture timer sources
        unmasked_req[s] = gated_req[s] && !cc_i_mask_in;
        maskable_req[s] = unmasked_req[s];
      end else if (s == int'(`IVP_SLOT_XREQ)) begin
        // the x flag guards only the external request slot
        unmasked_req[s] = gated_req[s] && !cc_x_mask_in;
        fixed_req[s]    = unmasked_req[s];
      end else begin
        // resets, software trap and illegal opcode trap never masked
        fixed_req[s] = gated_req[s];
      end
    end
  end

  // ----------------------------------------------------------------
  // priority search
  // ----------------------------------------------------------------
  ivp_pkg::ivp_pick_t fixed_pick;           // best non-maskable
  ivp_pkg::ivp_pick_t mask_pick;            // best maskable by address
  ivp_pkg::ivp_pick_t elev_pick;            // slot named for elevation
  ivp_pkg::ivp_pick_t win_pick;             // final winner

  // resets, traps and the external request lead, then elevated, then default address order
  always_comb begin
    fixed_pick = top_slot(fixed_req);
    mask_pick  = top_slot(maskable_req);
    elev_pick  = slot_of_value(priority_elevation_value_ff);
    // fixed sources beat an elevated one, so a reset is never delayed
    if (fixed_pick.found) begin
      win_pick = fixed_pick;
    end else if (elev_pick.found && maskable_req[elev_pick.slot]) begin
      // an elevated source only wins while it is pending and unmasked
      win_pick = elev_pick;
    end else begin
      win_pick = mask_pick;
    end
  end

  // ----------------------------------------------------------------
  // vector output
  // ----------------------------------------------------------------

  // next winner and its two-byte vector address
  always_comb begin
    nxt_irq_valid = win_pick.found;
    nxt_vector    = vector_ff;
    // idle keeps the last address so the cpu never sees a half-built one
    if (win_pick.found) begin
      nxt_vector = {`IVP_VEC_PAGE, 1'b1, win_pick.slot, 1'b0};
    end
  end

  // register the winner so the cpu sees a stable vector
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      irq_valid_ff <= 1'b0;
      vector_ff    <= {`IVP_VEC_PAGE, 1'b1, `IVP_SLOT_RESET, 1'b0};
    end else begin
      irq_valid_ff <= nxt_irq_valid;
      vector_ff    <= nxt_vector;
    end
  end

  // both outputs come straight from flops, free of glitches
  assign irq_valid_out   = irq_valid_ff;
  assign vector_addr_out = vector_ff;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------

  // write decode and read mux, read data valid the cycle after
  always_comb begin
    nxt_priority_elevation_value = priority_elevation_value_ff;
    nxt_chan_irq_enable          = chan_irq_enable_ff;
    nxt_ctrl                     = ctrl_ff;
    nxt_rdata                    = 8'h00;
    // read data fall back to zero, so a stale byte never lingers
    if (reg_wr_in) begin
      case (reg_addr_in)
        `IVP_OFS_PRIO: begin
          // any value is held; only maskable slots take effect
          nxt_priority_elevation_value = reg_wdata_in;
        end
        `IVP_OFS_CHEN: begin
          nxt_chan_irq_enable = reg_wdata_in;
        end
        `IVP_OFS_CTRL: begin
          nxt_ctrl = reg_wdata_in & `IVP_CTRL_MASK;
        end
        default: begin
          // status, vector and unmapped offsets ignore writes
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `IVP_OFS_PRIO: begin
          nxt_rdata = priority_elevation_value_ff;
        end
        `IVP_OFS_CHEN: begin
          nxt_rdata = chan_irq_enable_ff;
        end
        `IVP_OFS_CTRL: begin
          nxt_rdata = ctrl_ff;
        end
        `IVP_OFS_STAT: begin
          // bit 0 a source wins, bit 1 elevation value is usable
          nxt_rdata = {6'h00, elev_pick.found, irq_valid_ff};
        end
        `IVP_OFS_VLOW: begin
          nxt_rdata = vector_ff[7:0];
        end
        default: begin
          // unmapped offsets read as zero
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  // register file flops
  // software writes land here one cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      priority_elevation_value_ff <= `IVP_RST_PRIO;
      chan_irq_enable_ff          <= `IVP_RST_CHEN;
      ctrl_ff                     <= `IVP_RST_CTRL;
      rdata_ff                    <= 8'h00;
    end else begin
      priority_elevation_value_ff <= nxt_priority_elevation_value;
      chan_irq_enable_ff          <= nxt_chan_irq_enable;
      ctrl_ff                     <= nxt_ctrl;
      rdata_ff                    <= nxt_rdata;
    end
  end

  // the only path out for register contents
  assign reg_rdata_out = rdata_ff;

endmodule

`default_nettype wire

/* File: test/ivp_cpu_model.sv */
// processor side: holds the mask flags and fetches vectors
// assumes: flags come up set after reset, as a core leaves reset
`timescale 1ns/1ps
`default_nettype none
module ivp_cpu_model (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        i_cmd_in,
  input  wire logic        x_cmd_in,
  input  wire logic        irq_valid_in,
  input  wire logic [15:0] vector_in,
  output var  logic        cc_i_mask_out,
  output var  logic        cc_x_mask_out,
  output var  logic [15:0] fetched_out
);
  // flags follow the bench commands one cycle late
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cc_i_mask_out <= 1'b1;
      cc_x_mask_out <= 1'b1;
      fetched_out <= 16'hFFFE;
    end else begin
      cc_i_mask_out <= i_cmd_in;
      cc_x_mask_out <= x_cmd_in;
      if (irq_valid_in) begin
        fetched_out <= vector_in;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/ivp_sva.sv */
// port checker for the vector and priority resolver
// assumes: bound to ivp_top from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module ivp_sva #(
  parameter int NUM_SLOTS = 64   // vector slots above FF80
) (
  input wire logic                 sys_clk_in,
  input wire logic                 srst_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic [7:0]           reg_wdata_in,
  input wire logic                 reg_wr_in,
  input wire logic                 reg_rd_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic [NUM_SLOTS-1:0] src_req_in,
  input wire logic                 clk_fail_in,
  input wire logic                 cc_i_mask_in,
  input wire logic                 cc_x_mask_in,
  input wire logic                 irq_valid_out,
  input wire logic [15:0]          vector_addr_out
);
  // ----------------------------------------
  // properties, all on the system clock
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  property p_rst_out;
    $fell(srst_in) |-> !irq_valid_out && vector_addr_out == 16'hFFFE && reg_rdata_out == 8'h00;
  endproperty
  property p_rd_idle;
    !reg_rd_in |=> reg_rdata_out == 8'h00;
  endproperty
  property p_reset_top;
    src_req_in[63] |=> irq_valid_out && vector_addr_out == 16'hFFFE;
  endproperty
  property p_trap_unmasked;
    src_req_in[63:59] == 5'h01 && !clk_fail_in |=> irq_valid_out && vector_addr_out == 16'hFFF6;
  endproperty
  property p_x_mask;
    src_req_in[63:58] == 6'h01 && cc_x_mask_in && cc_i_mask_in && !clk_fail_in |=> !irq_valid_out;
  endproperty
  property p_i_mask;
    src_req_in[63:58] == 6'h00 && cc_i_mask_in && !clk_fail_in |=> !irq_valid_out;
  endproperty
  property p_vec_form;
    irq_valid_out |-> vector_addr_out[15:7] == 9'h1FF && !vector_addr_out[0];
  endproperty
  property p_vec_hold;
    !irq_valid_out && !$past(srst_in) |-> $stable(vector_addr_out);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_reset_top: assert property (p_reset_top) else $error("reset source lost");
  a_trap_unmasked: assert property (p_trap_unmasked) else $error("trap lost");
  a_x_mask: assert property (p_x_mask) else $error("external request not masked");
  a_i_mask: assert property (p_i_mask) else $error("maskable source passed");
  a_vec_form: assert property (p_vec_form) else $error("bad vector form");
  a_vec_hold: assert property (p_vec_hold) else $error("idle vector moved");
  cover property (irq_valid_out && vector_addr_out == 16'hFFC8);
  cover property (clk_fail_in ##1 vector_addr_out == 16'hFFFC);
  cover property (reg_rd_in ##1 reg_rdata_out != 8'h00);
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the vector resolver
// assumes: 40 MHz clock, cpu model drives the mask flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, cf = 1'b0;
  logic        i_cmd = 1'b1, x_cmd = 1'b1, i_m, x_m, valid;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rdata;
  logic [63:0] req = 64'h0;
  logic [15:0] vec, fetched;
  logic [15:0] vexp [5] = '{16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFCA, 16'hFFC8};
  logic [63:0] rk;
  int          err_total = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  ivp_top dut_u (.sys_clk_in(clk), .srst_in(srst), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .src_req_in(req),
    .clk_fail_in(cf), .cc_i_mask_in(i_m), .cc_x_mask_in(x_m), .irq_valid_out(valid),
    .vector_addr_out(vec));
  ivp_cpu_model cpu_u (.clk_in(clk), .srst_in(srst), .i_cmd_in(i_cmd), .x_cmd_in(x_cmd),
    .irq_valid_in(valid), .vector_in(vec), .cc_i_mask_out(i_m), .cc_x_mask_out(x_m),
    .fetched_out(fetched));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] e, string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, {8'h00, rdata}, {8'h00, e});
  endtask
  // apply requests and flags, expect a vector or 0 for none
  task automatic res(logic [63:0] r, logic ib, logic xb, logic f, logic [15:0] e, string nm);
    @(posedge clk);
    req <= r;
    i_cmd <= ib;
    x_cmd <= xb;
    cf <= f;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(nm, valid ? vec : 16'h0000, e);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd_chk(8'h00, 8'hF2, "prio");
    rd_chk(8'h01, 8'h00, "chen");
    rd_chk(8'h02, 8'h00, "ctrl");
    rd_chk(8'h05, 8'h00, "unmapped");
    $display("register reset test done");
    // each capture channel: disabled, masked, then winning
    for (int c = 0; c < 8; c++) begin
      wr_reg(8'h01, 8'h00);
      res(64'h1 << (55 - c), 1'b0, 1'b0, 1'b0, 16'h0000, "ch_off");
      wr_reg(8'h01, 8'h01 << c);
      res(64'h1 << (55 - c), 1'b1, 1'b0, 1'b0, 16'h0000, "ch_imask");
      res(64'h1 << (55 - c), 1'b0, 1'b0, 1'b0, 16'hFFEE - 16'(2 * c), "ch_vec");
    end
    // timer, accumulator and counter sources behind control bits
    for (int k = 0; k < 5; k++) begin
      rk = 64'h1 << vexp[k][6:1];
      wr_reg(8'h02, 8'h00);
      res(rk, 1'b0, 1'b0, 1'b0, 16'h0000, "ctl_off");
      wr_reg(8'h02, 8'h01 << k);
      res(rk, 1'b0, 1'b0, 1'b0, vexp[k], "ctl_vec");
    end
    $display("source table test done");
    wr_reg(8'h01, 8'hFF);
    res((64'h1 << 55) | (64'h1 << 48), 1'b0, 1'b0, 1'b0, 16'hFFEE, "order");
    wr_reg(8'h00, 8'hC8);
    res((64'h1 << 55) | (64'h1 << 36), 1'b0, 1'b0, 1'b0, 16'hFFC8, "elev_b");
    wr_reg(8'h00, 8'hE0);
    res((64'h1 << 55) | (64'h1 << 48), 1'b0, 1'b0, 1'b0, 16'hFFE0, "elev_ch7");
    // status and vector byte while channel 7 wins elevated
    rd_chk(8'h03, 8'h03, "stat");
    rd_chk(8'h04, 8'hE0, "vlow");
    // read-only offsets ignore writes and do not alias the elevation byte
    wr_reg(8'h04, 8'h00);
    wr_reg(8'h03, 8'h00);
    rd_chk(8'h00, 8'hE0, "prio_kept");
    res((64'h1 << 58) | (64'h1 << 48), 1'b0, 1'b0, 1'b0, 16'hFFF4, "xreq_top");
    res((64'h1 << 58) | (64'h1 << 55), 1'b0, 1'b1, 1'b0, 16'hFFEE, "xmask");
    res((64'h1 << 59) | (64'h1 << 58), 1'b1, 1'b1, 1'b0, 16'hFFF6, "swtrap");
    res((64'h1 << 60) | (64'h1 << 59), 1'b1, 1'b1, 1'b0, 16'hFFF8, "illop");
    // bit 7 of the control byte is not stored
    wr_reg(8'h02, 8'hA0);
    rd_chk(8'h02, 8'h20, "ctrl_b7");
    res(64'h0, 1'b1, 1'b1, 1'b1, 16'hFFFC, "clkmon");
    res(64'h1 << 63, 1'b1, 1'b1, 1'b1, 16'hFFFE, "reset_src");
    chk("fetched", fetched, 16'hFFFE);
    wr_reg(8'h02, 8'h60);
    res(64'h0, 1'b1, 1'b1, 1'b1, 16'h0000, "selfclk");
    wr_reg(8'h02, 8'h20);
    $display("priority test done");
    // reset in mid-run clears enables and returns elevation to F2
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd_chk(8'h00, 8'hF2, "prio_again");
    rd_chk(8'h02, 8'h00, "ctrl_again");
    res(64'h0, 1'b1, 1'b1, 1'b1, 16'h0000, "clkmon_off");
    $display("second reset test done");
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule
bind ivp_top ivp_sva #(.NUM_SLOTS(NUM_SLOTS)) sva_u (.sys_clk_in(sys_clk_in),
  .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .src_req_in(src_req_in), .clk_fail_in(clk_fail_in), .cc_i_mask_in(cc_i_mask_in),
  .cc_x_mask_in(cc_x_mask_in), .irq_valid_out(irq_valid_out),
  .vector_addr_out(vector_addr_out));
`default_nettype wire
